// ### design/cglc_top.sv
// The AHB-Lite register port is this design's own decision.
`default_nettype none
module cglc_top #(
	parameter int          NCH            = cglc_pkg::NCH,
	parameter int unsigned PULSE_STEP_CYC = cglc_pkg::PULSE_STEP_CYC
) (
	input  wire logic           sys_clk_i,
	input  wire logic           resetn_i,
	input  wire logic           hsel_i,
	input  wire logic [31:0]    haddr_i,
	input  wire logic [1:0]     htrans_i,
	input  wire logic           hwrite_i,
	input  wire logic [2:0]     hsize_i,
	input  wire logic [31:0]    hwdata_i,
	input  wire logic           hready_i,
	output logic      [31:0]    hrdata_o,
	output logic                hreadyout_o,
	output logic                hresp_o,
	input  wire logic [NCH-1:0] cnt_up_i,
	input  wire logic [NCH-1:0] cnt_down_i,
	input  wire logic [NCH-1:0] gate_input_pin_i,
	input  wire logic [NCH-1:0] latch_i,
	output logic      [NCH-1:0] cmp_o,
	output logic      [NCH-1:0] alarm_o
);
	localparam int DIVW = $clog2(PULSE_STEP_CYC);
	localparam logic [DIVW-1:0] DIV_LAST = DIVW'(PULSE_STEP_CYC - 1);
	localparam int SW = 4 * NCH;

	function automatic logic in_window(logic [31:0] v, logic [31:0] c, logic [7:0] h);
		logic signed [33:0] d, hh;
		d = $signed({{2{v[31]}}, v}) - $signed({{2{c[31]}}, c});
		hh = $signed({26'h0, h});
		return (d <= hh) && (d >= -hh);
	endfunction

	function automatic logic ch_hit(logic [11:0] a, int c);
		return a[11:cglc_pkg::CH_BLOCK_LSB] == 7'(c + int'(cglc_pkg::CH_FIRST_BLOCK));
	endfunction

	// input synchronisers: up, down, gate, latch
	logic [SW-1:0] in_s1, in_s2, in_s3;

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			in_s1 <= '0;
			in_s2 <= '0;
			in_s3 <= '0;
		end else begin
			in_s1 <= {latch_i, gate_input_pin_i, cnt_down_i, cnt_up_i};
			in_s2 <= in_s1;
			in_s3 <= in_s2;
		end
	end

	// bus state
	logic        wr_pend, rd_pend, next_wr_pend, next_rd_pend, next_hreadyout;
	logic [11:0] addr_q, next_addr_q;
	logic [31:0] next_hrdata;

	// channel state
	logic [7:0]               soft_gate, next_soft_gate;
	logic [31:0]              cfg    [NCH], next_cfg    [NCH];
	logic [31:0]              load_v [NCH], next_load_v [NCH];
	logic [31:0]              cmp_v  [NCH], next_cmp_v  [NCH];
	logic [7:0]               pw     [NCH], next_pw     [NCH];
	logic [7:0]               hyst   [NCH], next_hyst   [NCH];
	logic [31:0]              count  [NCH], next_count  [NCH];
	logic [31:0]              latch  [NCH], next_latch  [NCH];
	logic [7:0]               hlat   [NCH], next_hlat   [NCH];
	logic [7:0]               punits [NCH], next_punits [NCH];
	logic [DIVW-1:0]          pdiv   [NCH], next_pdiv   [NCH];
	logic [cglc_pkg::NEV-1:0] ev     [NCH], next_ev     [NCH];
	logic [NCH-1:0]           gate_q, hact, sdir, ldir, pbusy, pcond, inwin;
	logic [NCH-1:0]           next_gate_q, next_hact, next_sdir, next_ldir, next_pbusy;
	logic [NCH-1:0]           next_pcond, next_cmp, next_alarm;

	always_comb begin : bus_next
		logic take;
		take = hsel_i & htrans_i[1] & hready_i;
		next_wr_pend = take & hwrite_i;
		next_rd_pend = take & ~hwrite_i;
		next_addr_q = take ? haddr_i[11:0] : addr_q;
		next_hreadyout = ~(take & ~hwrite_i);
		next_hrdata = hrdata_o;
		if (rd_pend) begin
			next_hrdata = cglc_pkg::RST_WORD;
			if (addr_q == cglc_pkg::ADDR_SOFT_GATE) begin
				next_hrdata = {24'h0, soft_gate};
			end
			for (int c = 0; c < NCH; c++) begin
				if (ch_hit(addr_q, c)) begin
					unique case (addr_q[4:0])
						cglc_pkg::OFF_CFG:   next_hrdata = cfg[c];
						cglc_pkg::OFF_LOAD:  next_hrdata = load_v[c];
						cglc_pkg::OFF_CMP:   next_hrdata = cmp_v[c];
						cglc_pkg::OFF_PULSE: next_hrdata = {24'h0, pw[c]};
						cglc_pkg::OFF_HYST:  next_hrdata = {24'h0, hyst[c]};
						cglc_pkg::OFF_COUNT: next_hrdata = count[c];
						cglc_pkg::OFF_LATCH: next_hrdata = latch[c];
						cglc_pkg::OFF_STAT:  next_hrdata = {19'h0, ev[c],
							4'h0, ldir[c], cmp_o[c], hact[c], gate_q[c]};
						default: next_hrdata = cglc_pkg::RST_WORD;
					endcase
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_pend     <= 1'b0;
			rd_pend     <= 1'b0;
			addr_q      <= '0;
			hrdata_o    <= cglc_pkg::RST_WORD;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end else begin
			wr_pend     <= next_wr_pend;
			rd_pend     <= next_rd_pend;
			addr_q      <= next_addr_q;
			hrdata_o    <= next_hrdata;
			hreadyout_o <= next_hreadyout;
			hresp_o     <= 1'b0;
		end
	end

	always_comb begin : chan_next
		logic ig, upe, dne, pin, pin_old, stepu, stepd, cond, inw, fire, dok, hon;
		logic [cglc_pkg::NEV-1:0] newev, clr;
		logic [1:0] dir;
		cglc_pkg::cglc_cmp_mode_type mode;
		ig = 1'b0;
		upe = 1'b0;
		dne = 1'b0;
		pin = 1'b0;
		pin_old = 1'b0;
		stepu = 1'b0;
		stepd = 1'b0;
		cond = 1'b0;
		inw = 1'b0;
		fire = 1'b0;
		dok = 1'b0;
		hon = 1'b0;
		newev = '0;
		clr = '0;
		dir = '0;
		mode = cglc_pkg::CMP_NONE;
		inwin = '0;
		next_soft_gate = soft_gate;
		if (wr_pend && addr_q == cglc_pkg::ADDR_SOFT_GATE) begin
			next_soft_gate = hwdata_i[7:0];
		end
		for (int c = 0; c < NCH; c++) begin
			next_cfg[c] = cfg[c];
			next_load_v[c] = load_v[c];
			next_cmp_v[c] = cmp_v[c];
			next_pw[c] = pw[c];
			next_hyst[c] = hyst[c];
			next_count[c] = count[c];
			next_latch[c] = latch[c];
			next_hlat[c] = hlat[c];
			next_punits[c] = punits[c];
			next_pdiv[c] = pdiv[c];
			next_hact[c] = hact[c];
			next_sdir[c] = sdir[c];
			next_ldir[c] = ldir[c];
			next_pbusy[c] = pbusy[c];
			next_cmp[c] = cmp_o[c];
			clr = '0;
			newev = '0;
			fire = 1'b0;
			if (wr_pend && ch_hit(addr_q, c)) begin
				unique case (addr_q[4:0])
					cglc_pkg::OFF_CFG:   next_cfg[c] = hwdata_i;
					cglc_pkg::OFF_LOAD:  next_load_v[c] = hwdata_i;
					cglc_pkg::OFF_CMP:   next_cmp_v[c] = hwdata_i;
					cglc_pkg::OFF_PULSE: next_pw[c] = hwdata_i[7:0];
					cglc_pkg::OFF_HYST:  next_hyst[c] = hwdata_i[7:0];
					cglc_pkg::OFF_STAT:  clr = hwdata_i[cglc_pkg::STAT_EV_LSB +: cglc_pkg::NEV];
					default: clr = '0;
				endcase
			end
			// gate and counting
			pin = in_s2[2*NCH+c];
			pin_old = in_s3[2*NCH+c];
			ig = soft_gate[cglc_pkg::SOFT_GATE_LSB+c]
				& (~cfg[c][cglc_pkg::CFG_PIN_EN] | pin);
			next_gate_q[c] = ig;
			upe = in_s2[c] & ~in_s3[c];
			dne = in_s2[NCH+c] & ~in_s3[NCH+c];
			stepu = ig & upe & ~dne;
			stepd = ig & dne & ~upe;
			if (ig && !gate_q[c] && cfg[c][cglc_pkg::CFG_ABORT]) begin
				next_count[c] = load_v[c];
			end else if (stepu) begin
				next_count[c] = count[c] + 32'h1;
			end else if (stepd) begin
				next_count[c] = count[c] - 32'h1;
			end
			if (stepu || stepd) begin
				next_ldir[c] = stepu;
			end
			if (in_s2[3*NCH+c] && !in_s3[3*NCH+c]) begin
				next_latch[c] = count[c];
			end
			newev[cglc_pkg::EV_LOST] = ig & upe & dne;
			newev[cglc_pkg::EV_OVF] = ~hact[c] & ((stepu && count[c] == cglc_pkg::COUNT_MAX)
				| (stepd && count[c] == cglc_pkg::COUNT_MIN));
			newev[cglc_pkg::EV_GOPEN] = cfg[c][cglc_pkg::CFG_PIN_EN] & pin & ~pin_old;
			newev[cglc_pkg::EV_GCLS] = cfg[c][cglc_pkg::CFG_PIN_EN] & ~pin & pin_old;
			// compare
			mode = cglc_pkg::cglc_cmp_mode_type'(cfg[c][cglc_pkg::CFG_MODE_LSB +: 2]);
			dir = cfg[c][cglc_pkg::CFG_DIR_LSB +: 2];
			hon = hyst[c] >= cglc_pkg::HYST_MIN_ON;
			inw = in_window(count[c], cmp_v[c], hlat[c]);
			inwin[c] = inw;
			dok = (dir != cglc_pkg::DIR_UP && dir != cglc_pkg::DIR_DOWN)
				| (dir == cglc_pkg::DIR_UP && ldir[c])
				| (dir == cglc_pkg::DIR_DOWN && !ldir[c]);
			unique case (mode)
				cglc_pkg::CMP_GE: cond = $signed(count[c]) >= $signed(cmp_v[c]);
				cglc_pkg::CMP_LE: cond = $signed(count[c]) <= $signed(cmp_v[c]);
				cglc_pkg::CMP_NONE, cglc_pkg::CMP_PULSE: cond = count[c] == cmp_v[c];
			endcase
			next_pcond[c] = cond;
			newev[cglc_pkg::EV_REACH] = cond & ~pcond[c] & ~hact[c];
			if (mode == cglc_pkg::CMP_NONE) begin
				next_cmp[c] = cfg[c][cglc_pkg::CFG_PLAIN];
				next_hact[c] = 1'b0;
			end else if (mode != cglc_pkg::CMP_PULSE || pw[c] == 8'h0) begin
				if (hact[c]) begin
					if (!inw) begin
						next_hact[c] = 1'b0;
						next_cmp[c] = cond;
					end
				end else begin
					next_cmp[c] = cond;
					if (cond && hon) begin
						next_hact[c] = 1'b1;
						next_hlat[c] = hyst[c];
					end
				end
			end else begin
				if (hact[c]) begin
					if (!inw) begin
						next_hact[c] = 1'b0;
						fire = ldir[c] != sdir[c];
					end
				end else if (cond && !pcond[c] && dok) begin
					fire = 1'b1;
					if (hon) begin
						next_hact[c] = 1'b1;
						next_hlat[c] = hyst[c];
						next_sdir[c] = ldir[c];
					end
				end
			end
			// pulse timer runs to its end once started
			if (pbusy[c]) begin
				if (pdiv[c] == DIV_LAST) begin
					next_pdiv[c] = '0;
					if (punits[c] <= 8'h1) begin
						next_pbusy[c] = 1'b0;
					end else begin
						next_punits[c] = punits[c] - 8'h1;
					end
				end else begin
					next_pdiv[c] = pdiv[c] + DIVW'(1);
				end
			end else if (fire && pw[c] != 8'h0) begin
				next_pbusy[c] = 1'b1;
				next_punits[c] = pw[c];
				next_pdiv[c] = '0;
			end
			if (mode == cglc_pkg::CMP_PULSE && pw[c] != 8'h0) begin
				next_cmp[c] = next_pbusy[c];
			end
			next_ev[c] = (ev[c] & ~clr) | newev;
			next_alarm[c] = |(newev & cfg[c][cglc_pkg::CFG_ALM_LSB +: cglc_pkg::NEV]);
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			soft_gate <= '0;
			gate_q    <= '0;
			hact      <= '0;
			sdir      <= '0;
			ldir      <= '0;
			pbusy     <= '0;
			pcond     <= '0;
			cmp_o     <= '0;
			alarm_o   <= '0;
			for (int c = 0; c < NCH; c++) begin
				cfg[c]    <= cglc_pkg::RST_WORD;
				load_v[c] <= cglc_pkg::RST_WORD;
				cmp_v[c]  <= cglc_pkg::RST_WORD;
				pw[c]     <= '0;
				hyst[c]   <= '0;
				count[c]  <= cglc_pkg::RST_WORD;
				latch[c]  <= cglc_pkg::RST_WORD;
				hlat[c]   <= '0;
				punits[c] <= '0;
				pdiv[c]   <= '0;
				ev[c]     <= '0;
			end
		end else begin
			soft_gate <= next_soft_gate;
			gate_q    <= next_gate_q;
			hact      <= next_hact;
			sdir      <= next_sdir;
			ldir      <= next_ldir;
			pbusy     <= next_pbusy;
			pcond     <= next_pcond;
			cmp_o     <= next_cmp;
			alarm_o   <= next_alarm;
			cfg       <= next_cfg;
			load_v    <= next_load_v;
			cmp_v     <= next_cmp_v;
			pw        <= next_pw;
			hyst      <= next_hyst;
			count     <= next_count;
			latch     <= next_latch;
			hlat      <= next_hlat;
			punits    <= next_punits;
			pdiv      <= next_pdiv;
			ev        <= next_ev;
		end
	end

	// checking helpers: length of the running pulse and its programmed width
	logic [31:0] plen [NCH];
	logic [7:0]  pws  [NCH];
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int c = 0; c < NCH; c++) begin
				plen[c] <= '0;
				pws[c]  <= '0;
			end
		end else begin
			for (int c = 0; c < NCH; c++) begin
				plen[c] <= pbusy[c] ? plen[c] + 32'h1 : 32'h0;
				if (pbusy[c] && plen[c] == 32'h0) begin
					pws[c] <= punits[c];
				end
			end
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	for (genvar c = 0; c < NCH; c++) begin : g_chk
		chk_gate_and: assert property (
			gate_q[c] == $past(soft_gate[cglc_pkg::SOFT_GATE_LSB+c]
				&& (!cfg[c][cglc_pkg::CFG_PIN_EN] || in_s2[2*NCH+c])))
			else $error("internal gate differs from soft and pin gate");
		chk_gate_soft: assert property (
			(!cfg[c][cglc_pkg::CFG_PIN_EN] && soft_gate[cglc_pkg::SOFT_GATE_LSB+c]) |=> gate_q[c])
			else $error("gate closed with pin gate disabled and soft gate set");
		chk_abort_load: assert property (
			($rose(gate_q[c]) && $past(cfg[c][cglc_pkg::CFG_ABORT])) |-> count[c] == $past(load_v[c]))
			else $error("count not reloaded on gate reopen");
		chk_hold_closed: assert property (
			!gate_q[c] |-> $stable(count[c]))
			else $error("count moved while gate closed");
		chk_latch_copy: assert property (
			(in_s2[3*NCH+c] && !in_s3[3*NCH+c]) |=> latch[c] == $past(count[c]))
			else $error("latch did not capture count");
		chk_ge_output: assert property (
			(cfg[c][cglc_pkg::CFG_MODE_LSB +: 2] == 2'(cglc_pkg::CMP_GE) && !hact[c]
				&& hyst[c] < cglc_pkg::HYST_MIN_ON)
			|=> cmp_o[c] == ($signed($past(count[c])) >= $signed($past(cmp_v[c]))))
			else $error("at-or-above output wrong");
		chk_le_output: assert property (
			(cfg[c][cglc_pkg::CFG_MODE_LSB +: 2] == 2'(cglc_pkg::CMP_LE) && !hact[c]
				&& hyst[c] < cglc_pkg::HYST_MIN_ON)
			|=> cmp_o[c] == ($signed($past(count[c])) <= $signed($past(cmp_v[c]))))
			else $error("below output wrong");
		chk_pulse_len: assert property (
			$fell(pbusy[c]) |-> plen[c] == 32'(pws[c]) * 32'(PULSE_STEP_CYC))
			else $error("pulse length differs from programmed width");
		chk_no_pulse_win: assert property (
			$rose(pbusy[c]) |-> $past(!hact[c] || !inwin[c]))
			else $error("pulse started inside active window");
		chk_hyst_hold: assert property (
			(hact[c] && inwin[c] && cfg[c][cglc_pkg::CFG_MODE_LSB +: 2] != 2'(cglc_pkg::CMP_NONE)
				&& !pbusy[c]) |=> $stable(cmp_o[c]))
			else $error("output changed inside hysteresis window");
		chk_hyst_keep: assert property (
			(hact[c] && $past(hact[c])) |-> $stable(hlat[c]))
			else $error("hysteresis range changed while active");
		cov_abort: cover property ($rose(gate_q[c]) && cfg[c][cglc_pkg::CFG_ABORT]);
		cov_pulse: cover property ($fell(pbusy[c]) ##1 $rose(pbusy[c]));
		cov_hyst: cover property ($rose(hact[c]) ##[1:200] $fell(hact[c]));
		cov_latch: cover property (in_s2[3*NCH+c] && !in_s3[3*NCH+c] && count[c] != 32'h0);
	end
endmodule // cglc_top
`default_nettype wire

// ### design/cglc_pkg.sv
// Overview of operation
// - internal gate is soft AND pin gate
// - pin gate disabled: soft gate alone
// - abort: reload load value on reopen
// - interrupt: hold count while gate closed
// - latch edge copies count to latch
// - four compare output modes per channel
// - at-or-above: out when count >= compare
// - below: out when count <= compare
// - pulse mode: timed pulse on reaching compare
// - main direction: reach pulse only in that direction
// - pulse width 0..510 ms, 2 ms steps
// - width zero: out while condition holds
// - timing starts with output; error under 1ms
// - started pulse always runs full length
// - hysteresis 0..255; 0 and 1 disable
// - hysteresis also gates overflow/underflow and reach events
// - window holds result until count leaves
// - at-or-above: on leave, out follows condition
// - pulse mode: store direction, no pulse inside
// - leave opposite: pulse; same direction: none
// - per-channel alarm on enabled events
`default_nettype none
package cglc_pkg;
	localparam int          NCH            = 3;
	localparam int unsigned CLK_HZ         = 10_000_000;
	localparam int unsigned PULSE_STEP_MS  = 2;
	localparam int unsigned PULSE_STEP_CYC = CLK_HZ / 1000 * PULSE_STEP_MS;

	localparam logic [11:0] ADDR_SOFT_GATE = 12'h00c;
	localparam int          SOFT_GATE_LSB  = 4;
	localparam int          CH_BLOCK_LSB   = 5;
	localparam logic [6:0]  CH_FIRST_BLOCK = 7'h01;

	localparam logic [4:0]  OFF_CFG   = 5'h00;
	localparam logic [4:0]  OFF_LOAD  = 5'h04;
	localparam logic [4:0]  OFF_CMP   = 5'h08;
	localparam logic [4:0]  OFF_PULSE = 5'h0c;
	localparam logic [4:0]  OFF_HYST  = 5'h10;
	localparam logic [4:0]  OFF_COUNT = 5'h14;
	localparam logic [4:0]  OFF_LATCH = 5'h18;
	localparam logic [4:0]  OFF_STAT  = 5'h1c;

	localparam int CFG_PIN_EN   = 0;
	localparam int CFG_ABORT    = 1;
	localparam int CFG_MODE_LSB = 2;
	localparam int CFG_DIR_LSB  = 4;
	localparam int CFG_PLAIN    = 6;
	localparam int CFG_ALM_LSB  = 8;

	localparam int NEV      = 5;
	localparam int EV_GOPEN = 0;
	localparam int EV_GCLS  = 1;
	localparam int EV_OVF   = 2;
	localparam int EV_REACH = 3;
	localparam int EV_LOST  = 4;
	localparam int STAT_EV_LSB = 8;

	localparam logic [1:0]  DIR_UP   = 2'h1;
	localparam logic [1:0]  DIR_DOWN = 2'h2;
	localparam logic [7:0]  HYST_MIN_ON = 8'h02;
	localparam logic [31:0] COUNT_MAX   = 32'h7fffffff;
	localparam logic [31:0] COUNT_MIN   = 32'h80000000;
	localparam logic [31:0] RST_WORD    = 32'h00000000;

	typedef enum logic [1:0] {CMP_NONE, CMP_GE, CMP_LE, CMP_PULSE} cglc_cmp_mode_type;
endpackage
`default_nettype wire

// ### testbench/cglc_field.sv
`default_nettype none
module cglc_field #(
	parameter int NCH = 3
) (
	input  wire logic           sys_clk_i,
	output logic      [NCH-1:0] cnt_up_o,
	output logic      [NCH-1:0] cnt_down_o,
	output logic      [NCH-1:0] gate_pin_o,
	output logic      [NCH-1:0] latch_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		cnt_up_o   = '0;
		cnt_down_o = '0;
		gate_pin_o = '0;
		latch_o    = '0;
	end

	// encoder edges held long enough to pass the input synchroniser
	task automatic step(input int ch, input logic up, input int n);
		repeat (n) begin
			if (up) begin
				cnt_up_o[ch] <= 1'b1;
			end else begin
				cnt_down_o[ch] <= 1'b1;
			end
			repeat (4) @(posedge sys_clk_i);
			cnt_up_o[ch]   <= 1'b0;
			cnt_down_o[ch] <= 1'b0;
			repeat (4) @(posedge sys_clk_i);
		end
	endtask

	task automatic set_gate(input int ch, input logic v);
		gate_pin_o[ch] <= v;
		repeat (4) @(posedge sys_clk_i);
	endtask

	task automatic latch(input int ch);
		latch_o[ch] <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		latch_o[ch] <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
	endtask
endmodule // cglc_field
`default_nettype wire

// ### testbench/counter_gate_latch_compare_tb.sv
`default_nettype none
module counter_gate_latch_compare_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic        sys_clk;
	logic        resetn;
	logic        hsel;
	logic        hwrite;
	logic        hready;
	logic        hresp;
	logic [1:0]  htrans;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [2:0]  cmp;
	logic [2:0]  alarm;
	logic [2:0]  up;
	logic [2:0]  dn;
	logic [2:0]  gpin;
	logic [2:0]  lat;
	int          error_cnt = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          run = 0;
	int          hi_len = 0;
	int          rises = 0;
	int          alms = 0;
	int          n;
	int          m;

	cglc_top #(.PULSE_STEP_CYC(4)) dut_u (
		.sys_clk_i(sys_clk), .resetn_i(resetn), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.cnt_up_i(up), .cnt_down_i(dn), .gate_input_pin_i(gpin), .latch_i(lat),
		.cmp_o(cmp), .alarm_o(alarm)
	);

	cglc_field field_u (
		.sys_clk_i(sys_clk), .cnt_up_o(up), .cnt_down_o(dn), .gate_pin_o(gpin), .latch_o(lat)
	);

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// output monitor and run limit, sampled away from the active edge
	always @(negedge sys_clk) begin
		cyc++;
		if (cmp[0] === 1'b1) begin
			if (run == 0) rises++;
			run++;
		end else begin
			if (run != 0) hi_len = run;
			run = 0;
		end
		if (alarm[0] === 1'b1) alms++;
		if (cyc == 30000) begin
			error_cnt++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic wait_rdy(output logic [31:0] q);
		logic ok;
		do begin
			@(negedge sys_clk);
			ok = hready;
			q  = hrdata;
			@(posedge sys_clk);
		end while (ok !== 1'b1);
	endtask

	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
			output logic [31:0] q);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		wait_rdy(q);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy(q);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic expect_reg(input string what, input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		check(what, exp, q);
		check("hresp_o", 32'h0, {31'h0, hresp});
	endtask

	task automatic expect_out(input logic exp);
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		check("cmp_o", {31'h0, exp}, {31'h0, cmp[0]});
		@(posedge sys_clk);
	endtask

	function automatic logic [31:0] ca(input int ch, input logic [4:0] off);
		return 32'h20 * 32'(ch + 1) + {27'h0, off};
	endfunction

	initial begin
		resetn = 1'b0;
		hsel   = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr  = 32'h0;
		hwdata = 32'h0;
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		expect_reg("soft_gate", 32'hc, 32'h0);
		expect_reg("cfg1", ca(1, 5'h00), 32'h0);
		wr(32'h800, 32'hffffffff);
		expect_reg("unmapped", 32'h800, 32'h0);
		// channel 1 gate: soft bit 5 with the pin gate enabled
		wr(ca(1, 5'h00), 32'h1);
		wr(32'hc, 32'h20);
		field_u.step(1, 1'b1, 2);
		field_u.step(0, 1'b1, 1);
		expect_reg("count1", ca(1, 5'h14), 32'h0);
		expect_reg("count0", ca(0, 5'h14), 32'h0);
		field_u.set_gate(1, 1'b1);
		field_u.step(1, 1'b1, 2);
		expect_reg("count1", ca(1, 5'h14), 32'h2);
		field_u.set_gate(1, 1'b0);
		wr(ca(1, 5'h00), 32'h0);
		field_u.step(1, 1'b1, 1);
		expect_reg("count1", ca(1, 5'h14), 32'h3);
		// interrupt behaviour: count held while closed
		wr(32'hc, 32'h0);
		field_u.step(1, 1'b0, 2);
		expect_reg("count1", ca(1, 5'h14), 32'h3);
		wr(32'hc, 32'h20);
		field_u.step(1, 1'b1, 1);
		expect_reg("count1", ca(1, 5'h14), 32'h4);
		// abort behaviour: reload on reopening
		wr(ca(1, 5'h04), 32'h64);
		wr(ca(1, 5'h00), 32'h2);
		wr(32'hc, 32'h0);
		wr(32'hc, 32'h20);
		field_u.step(1, 1'b1, 1);
		expect_reg("count1", ca(1, 5'h14), 32'h65);
		field_u.latch(1);
		expect_reg("latch1", ca(1, 5'h18), 32'h65);
		// channel 0 compare modes, compare value 2
		wr(32'hc, 32'h10);
		wr(ca(0, 5'h08), 32'h2);
		wr(ca(0, 5'h00), 32'h40);
		expect_out(1'b1);
		wr(ca(0, 5'h00), 32'h0);
		expect_out(1'b0);
		wr(ca(0, 5'h00), 32'h804);
		expect_out(1'b0);
		n = alms;
		field_u.step(0, 1'b1, 2);
		expect_out(1'b1);
		check("alarms", n + 1, alms);
		expect_reg("stat0", ca(0, 5'h1c), 32'h80d);
		wr(ca(0, 5'h1c), 32'h800);
		expect_reg("stat0", ca(0, 5'h1c), 32'hd);
		wr(ca(0, 5'h00), 32'h8);
		expect_out(1'b1);
		field_u.step(0, 1'b1, 1);
		expect_out(1'b0);
		// timed pulse, main direction up, 3 units of 4 cycles
		wr(ca(0, 5'h00), 32'h1c);
		wr(ca(0, 5'h0c), 32'h3);
		wr(ca(0, 5'h08), 32'h5);
		n = rises;
		field_u.step(0, 1'b1, 3);
		repeat (4) @(posedge sys_clk);
		check("pulse_len", 32'd12, hi_len);
		check("pulses", n + 1, rises);
		field_u.step(0, 1'b0, 1);
		check("pulses", n + 1, rises);
		wr(ca(0, 5'h0c), 32'h0);
		expect_out(1'b1);
		field_u.step(0, 1'b1, 1);
		expect_out(1'b0);
		// at-or-above with window 3..7
		field_u.step(0, 1'b0, 4);
		wr(ca(0, 5'h00), 32'h4);
		wr(ca(0, 5'h10), 32'h2);
		expect_out(1'b0);
		field_u.step(0, 1'b1, 3);
		expect_out(1'b1);
		field_u.step(0, 1'b0, 1);
		expect_out(1'b1);
		field_u.step(0, 1'b0, 1);
		expect_out(1'b1);
		field_u.step(0, 1'b0, 1);
		expect_out(1'b0);
		wr(ca(0, 5'h10), 32'h1);
		field_u.step(0, 1'b1, 3);
		expect_out(1'b1);
		field_u.step(0, 1'b0, 1);
		expect_out(1'b0);
		// pulse mode with window 3..7, width 1 unit
		wr(ca(0, 5'h00), 32'h80c);
		wr(ca(0, 5'h0c), 32'h1);
		wr(ca(0, 5'h10), 32'h2);
		n = rises;
		m = alms;
		field_u.step(0, 1'b1, 1);
		check("pulses", n + 1, rises);
		check("alarms", m + 1, alms);
		wr(ca(0, 5'h10), 32'h4);
		field_u.step(0, 1'b0, 1);
		field_u.step(0, 1'b1, 1);
		check("pulses", n + 1, rises);
		check("alarms", m + 1, alms);
		field_u.step(0, 1'b0, 3);
		check("pulses", n + 2, rises);
		field_u.step(0, 1'b1, 3);
		check("pulses", n + 3, rises);
		check("alarms", m + 2, alms);
		field_u.step(0, 1'b1, 5);
		check("pulses", n + 3, rises);
		give_verdict();
	end
endmodule // counter_gate_latch_compare_tb
`default_nettype wire
